/* include/psec_regs.vh */
`ifndef PSEC_REGS_VH
`define PSEC_REGS_VH

// Register indices (printed offsets); byte address is four times the index
`define PSEC_IDX_FCC        6'h14
`define PSEC_IDX_REC        6'h15
`define PSEC_IDX_STS        6'h10
`define PSEC_IDX_IRQ_STAT   6'h18
`define PSEC_IDX_IRQ_MASK   6'h19

// Combined status field positions
`define PSEC_STS_LINK       0
`define PSEC_STS_SPEED10    1
`define PSEC_STS_DUPLEX     2
`define PSEC_STS_LOOPBACK   3
`define PSEC_STS_ANEG_DONE  4
`define PSEC_STS_JABBER     5
`define PSEC_STS_FC_LATCH   11
`define PSEC_STS_RE_LATCH   13

// Interrupt status/mask bits
`define PSEC_IRQ_FC         0
`define PSEC_IRQ_RE         1
`define PSEC_IRQ_W          2

`define PSEC_CNT_W          8
`define PSEC_CNT_MAX        8'hff
`define PSEC_CNT_ZERO       8'h00

// AXI responses
`define PSEC_RESP_OKAY      2'b00
`define PSEC_RESP_SLVERR    2'b10

`endif

/* hdl/psec_sat_counter.v */
`timescale 1ns/100ps

module psec_sat_counter #(
	parameter W = 8
) (
	input  wire         clk,
	input  wire         rst,
	input  wire         ce,
	input  wire         inc,
	input  wire         clr,
	output reg  [W-1:0] count_r
);

	wire [W-1:0] max_val = {W{1'b1}};
	wire [W-1:0] zero    = {W{1'b0}};

	// Clear on read reloads to one when an event lands in the same cycle
	always @(posedge clk) begin
		if (rst) begin
			count_r <= zero;
		end else if (ce) begin
			if (clr) begin
				count_r <= inc ? {{(W-1){1'b0}}, 1'b1} : zero;
			end else if (inc && (count_r != max_val)) begin
				count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // psec_sat_counter

/* hdl/psec_status_counters.v */
// Functional notes
// - Jabber bit five, meaningful at 10 Mb/s
// - Jabber copy mirrors basic status, read keeps
// - Bit four shows negotiation complete
// - Bit three shows loopback enabled
// - Bit two shows full duplex
// - Bit one high means 10 Mb/s
// - Bit zero mirrors link, read keeps
// - False carrier tally counts, clears on read
// - False carrier tally sticks at FFh
// - Counter upper byte reads zero, ignores writes
// - Receive error tally counts symbol errors, clears
// - At most once per carrier event
// - No count when collision present
// - Receive error tally saturates, no rollover
// - Bit thirteen latches receive error, cleared reading
// - Bit eleven latches false carrier, cleared reading
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "psec_regs.vh"

module psec_status_counters #(
	parameter CNT_W = `PSEC_CNT_W
) (
	input  wire        CLOCK,
	input  wire        SYS_RST,
	input  wire        CLK_EN,
	// Line status
	input  wire        JABBER,
	input  wire        ANEG_DONE,
	input  wire        LOOPBACK_EN,
	input  wire        FULL_DUPLEX,
	input  wire        SPEED_10,
	input  wire        LINK_UP,
	// Receive events
	input  wire        FALSE_CARRIER,
	input  wire        CARRIER,
	input  wire        SYMBOL_ERR,
	input  wire        COLLISION,
	// AXI4-Lite slave
	input  wire [7:0]  S_AXI_AWADDR,
	input  wire        S_AXI_AWVALID,
	output wire        S_AXI_AWREADY,
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output wire        S_AXI_WREADY,
	output reg  [1:0]  S_AXI_BRESP,
	output reg         S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	input  wire [7:0]  S_AXI_ARADDR,
	input  wire        S_AXI_ARVALID,
	output wire        S_AXI_ARREADY,
	output reg  [31:0] S_AXI_RDATA,
	output reg  [1:0]  S_AXI_RRESP,
	output reg         S_AXI_RVALID,
	input  wire        S_AXI_RREADY,
	output wire        IRQ
);

	wire [CNT_W-1:0] false_carrier_tally;
	wire [CNT_W-1:0] receive_error_tally;

	reg              fc_latch_r;
	reg              re_latch_r;
	reg              re_done_r;
	reg [`PSEC_IRQ_W-1:0] irq_stat_r;
	reg [`PSEC_IRQ_W-1:0] irq_mask_r;

	// Write channel capture: address and data may arrive in either order
	reg              aw_held_r;
	reg [7:0]        aw_addr_r;
	reg              w_held_r;
	reg [31:0]       w_data_r;
	reg [3:0]        w_strb_r;

	assign S_AXI_AWREADY = ~aw_held_r & ~S_AXI_BVALID;
	assign S_AXI_WREADY  = ~w_held_r & ~S_AXI_BVALID;
	assign S_AXI_ARREADY = ~S_AXI_RVALID;

	wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY & CLK_EN;
	wire w_take  = S_AXI_WVALID & S_AXI_WREADY & CLK_EN;
	wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY & CLK_EN;

	wire [7:0]  wr_addr = aw_held_r ? aw_addr_r : S_AXI_AWADDR;
	wire [31:0] wr_data = w_held_r ? w_data_r : S_AXI_WDATA;
	wire [3:0]  wr_strb = w_held_r ? w_strb_r : S_AXI_WSTRB;
	wire        wr_go   = (aw_held_r | aw_take) & (w_held_r | w_take) & CLK_EN;
	wire [5:0]  wr_idx  = wr_addr[7:2];
	wire [5:0]  rd_idx  = S_AXI_ARADDR[7:2];

	// Clear-on-read fires only when the read is accepted
	wire rd_fcc = ar_take && (rd_idx == `PSEC_IDX_FCC);
	wire rd_rec = ar_take && (rd_idx == `PSEC_IDX_REC);

	// Receive error: one count per carrier event; a collision vetoes the rest of it
	// A count taken before a late collision stands: undoing it would need a delay
	wire re_event = CARRIER & SYMBOL_ERR & ~COLLISION & ~re_done_r;

	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			re_done_r <= 1'b0;
		end else if (CLK_EN) begin
			if (!CARRIER)
				re_done_r <= 1'b0;
			else if (re_event || COLLISION)
				re_done_r <= 1'b1;
		end
	end

	psec_sat_counter #(
		.W       (CNT_W)
	) u_fc_cnt (
		.clk     (CLOCK),
		.rst     (SYS_RST),
		.ce      (CLK_EN),
		.inc     (FALSE_CARRIER),
		.clr     (rd_fcc),
		.count_r (false_carrier_tally)
	);

	psec_sat_counter #(
		.W       (CNT_W)
	) u_re_cnt (
		.clk     (CLOCK),
		.rst     (SYS_RST),
		.ce      (CLK_EN),
		.inc     (re_event),
		.clr     (rd_rec),
		.count_r (receive_error_tally)
	);

	// Latches: a new event wins over the read clear
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			fc_latch_r <= 1'b0;
			re_latch_r <= 1'b0;
		end else if (CLK_EN) begin
			if (FALSE_CARRIER)
				fc_latch_r <= 1'b1;
			else if (rd_fcc)
				fc_latch_r <= 1'b0;
			if (re_event)
				re_latch_r <= 1'b1;
			else if (rd_rec)
				re_latch_r <= 1'b0;
		end
	end

	// Line status registered so every field reads zero out of reset
	localparam STS_W = `PSEC_STS_JABBER + 1;
	wire [STS_W-1:0] sts_in = {
		JABBER,
		ANEG_DONE,
		LOOPBACK_EN,
		FULL_DUPLEX,
		SPEED_10,
		LINK_UP
	};
	reg  [STS_W-1:0] sts_r;

	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			sts_r <= {STS_W{1'b0}};
		end else if (CLK_EN) begin
			sts_r <= sts_in;
		end
	end

	// Combined status view; line bits mirror, bits 11 and 13 latch; never cleared by reading it
	wire [15:0] combined_phy_status;
	assign combined_phy_status = {
		2'b00,
		re_latch_r,
		1'b0,
		fc_latch_r,
		5'b00000,
		sts_r[`PSEC_STS_JABBER],
		sts_r[`PSEC_STS_ANEG_DONE],
		sts_r[`PSEC_STS_LOOPBACK],
		sts_r[`PSEC_STS_DUPLEX],
		sts_r[`PSEC_STS_SPEED10],
		sts_r[`PSEC_STS_LINK]
	};

	// Interrupt status: set wins over write-one-to-clear
	wire [`PSEC_IRQ_W-1:0] irq_set = {re_event, FALSE_CARRIER};
	wire                   wr_stat = wr_go && (wr_idx == `PSEC_IDX_IRQ_STAT) && wr_strb[0];
	wire                   wr_mask = wr_go && (wr_idx == `PSEC_IDX_IRQ_MASK) && wr_strb[0];

	genvar g;
	generate
		for (g = 0; g < `PSEC_IRQ_W; g = g + 1) begin : g_irq
			always @(posedge CLOCK) begin
				if (SYS_RST) begin
					irq_stat_r[g] <= 1'b0;
				end else if (CLK_EN) begin
					if (irq_set[g])
						irq_stat_r[g] <= 1'b1;
					else if (wr_stat && wr_data[g])
						irq_stat_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	assign IRQ = |(irq_stat_r & irq_mask_r);

	// Map check for writes; counters and status accept and ignore data
	reg wr_known;
	always @* begin
		case (wr_idx)
			`PSEC_IDX_FCC, `PSEC_IDX_REC, `PSEC_IDX_STS,
			`PSEC_IDX_IRQ_STAT, `PSEC_IDX_IRQ_MASK: wr_known = 1'b1;
			default: wr_known = 1'b0;
		endcase
	end

	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			aw_held_r    <= 1'b0;
			aw_addr_r    <= 8'h00;
			w_held_r     <= 1'b0;
			w_data_r     <= 32'h00000000;
			w_strb_r     <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `PSEC_RESP_OKAY;
			irq_mask_r   <= {`PSEC_IRQ_W{1'b0}};
		end else if (CLK_EN) begin
			if (wr_go) begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_known ? `PSEC_RESP_OKAY : `PSEC_RESP_SLVERR;
				if (wr_mask)
					irq_mask_r <= wr_data[`PSEC_IRQ_W-1:0];
			end else begin
				if (aw_take) begin
					aw_held_r <= 1'b1;
					aw_addr_r <= S_AXI_AWADDR;
				end
				if (w_take) begin
					w_held_r <= 1'b1;
					w_data_r <= S_AXI_WDATA;
					w_strb_r <= S_AXI_WSTRB;
				end
				if (S_AXI_BVALID && S_AXI_BREADY)
					S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Read: data sampled before any same-cycle event lands
	reg [31:0] rd_word;
	reg        rd_ok;
	always @* begin
		rd_word = 32'h00000000;
		rd_ok   = 1'b1;
		case (rd_idx)
			`PSEC_IDX_FCC: rd_word[CNT_W-1:0] = false_carrier_tally;
			`PSEC_IDX_REC: rd_word[CNT_W-1:0] = receive_error_tally;
			`PSEC_IDX_STS: rd_word[15:0] = combined_phy_status;
			`PSEC_IDX_IRQ_STAT: rd_word[`PSEC_IRQ_W-1:0] = irq_stat_r;
			`PSEC_IDX_IRQ_MASK: rd_word[`PSEC_IRQ_W-1:0] = irq_mask_r;
			default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h00000000;
			S_AXI_RRESP  <= `PSEC_RESP_OKAY;
		end else if (CLK_EN) begin
			if (ar_take) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= rd_word;
				S_AXI_RRESP  <= rd_ok ? `PSEC_RESP_OKAY : `PSEC_RESP_SLVERR;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

endmodule // psec_status_counters

/* test/psec_chk.sv */
`timescale 1ns/100ps
module psec_chk (
	input wire        CLOCK,
	input wire        SYS_RST,
	input wire        FALSE_CARRIER,
	input wire [7:0]  S_AXI_ARADDR,
	input wire        S_AXI_ARVALID,
	input wire        S_AXI_ARREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire        S_AXI_RVALID,
	input wire        S_AXI_RREADY,
	input wire        S_AXI_AWREADY,
	input wire        S_AXI_BVALID,
	input wire        S_AXI_BREADY,
	input wire        IRQ
);
	reg  [7:0] addr_r;
	reg        new_r;
	reg  [7:0] fc_r;
	wire       take = S_AXI_ARVALID && S_AXI_ARREADY;
	// Reference tally: a pulse on the clearing edge must survive
	always @(posedge CLOCK) begin
		new_r <= !SYS_RST && take;
		if (take)
			addr_r <= S_AXI_ARADDR;
		if (SYS_RST)
			fc_r <= 8'h00;
		else if (take && S_AXI_ARADDR == 8'h50)
			fc_r <= {7'h00, FALSE_CARRIER};
		else if (FALSE_CARRIER && fc_r != 8'hff)
			fc_r <= fc_r + 8'h01;
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	AST_RD_NEXT: assert property (take |=> S_AXI_RVALID)
		else $error("read answer late");
	AST_RD_DROP: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
		else $error("read answer stuck");
	AST_ONE_RD: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("second read taken");
	AST_WR_DROP: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write answer stuck");
	AST_WR_BUSY: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
		else $error("second write taken");
	AST_RST_IDLE: assert property ($fell(SYS_RST) |-> !IRQ && !S_AXI_RVALID)
		else $error("not idle after reset");
	AST_UPPER: assert property (new_r && addr_r[7:3] == 5'h0a |-> !(|S_AXI_RDATA[31:8]))
		else $error("counter upper bits set");
	AST_FC_CNT: assert property (new_r && addr_r == 8'h50 |-> S_AXI_RDATA[7:0] == $past(fc_r))
		else $error("false carrier tally wrong");
endmodule // psec_chk
bind psec_status_counters psec_chk u_psec_chk (.CLOCK, .SYS_RST, .FALSE_CARRIER,
	.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
	.S_AXI_RREADY, .S_AXI_AWREADY, .S_AXI_BVALID, .S_AXI_BREADY, .IRQ);

/* test/psec_mgmt.sv */
`timescale 1ns/100ps
module psec_mgmt (
	input  wire        clk,
	output reg  [7:0]  awaddr,
	output reg         awvalid,
	input  wire        awready,
	output reg  [31:0] wdata,
	output reg         wvalid,
	input  wire        wready,
	input  wire        bvalid,
	output reg         bready,
	output reg  [7:0]  araddr,
	output reg         arvalid,
	input  wire        arready,
	input  wire        rvalid,
	output reg         rready
);
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready} = 0;
		{araddr, arvalid, rready} = 0;
	end
	// Released lines show the inverse, never a stale copy
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		repeat ($urandom % 3) @(posedge clk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge clk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		araddr <= ~a;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask
endmodule // psec_mgmt

/* test/test_psec_status_counters.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module test_psec_status_counters;
	logic        CLOCK = 0, SYS_RST = 1, FALSE_CARRIER = 0;
	logic        CARRIER = 0, SYMBOL_ERR = 0, COLLISION = 0;
	logic [5:0]  sts = 0;
	wire  [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
	wire  [31:0] S_AXI_WDATA, S_AXI_RDATA;
	wire  [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	wire         S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, IRQ;
	wire         S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
	wire         S_AXI_RVALID, S_AXI_RREADY;
	logic [65:0] exp_q[$];
	logic [65:0] e;
	logic [1:0]  bq[$];
	logic [1:0]  br;
	int          bad_count = 0, n_checks = 0, cyc = 0, i;
	psec_status_counters u_psec_status_counters (.CLOCK, .SYS_RST, .CLK_EN(1'b1),
		.JABBER(sts[5]), .ANEG_DONE(sts[4]), .LOOPBACK_EN(sts[3]),
		.FULL_DUPLEX(sts[2]), .SPEED_10(sts[1]), .LINK_UP(sts[0]),
		.FALSE_CARRIER, .CARRIER, .SYMBOL_ERR, .COLLISION, .S_AXI_AWADDR,
		.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
		.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
		.S_AXI_RVALID, .S_AXI_RREADY, .IRQ);
	psec_mgmt u_psec_mgmt (.clk(CLOCK), .awaddr(S_AXI_AWADDR), .awvalid(S_AXI_AWVALID),
		.awready(S_AXI_AWREADY), .wdata(S_AXI_WDATA), .wvalid(S_AXI_WVALID),
		.wready(S_AXI_WREADY), .bvalid(S_AXI_BVALID), .bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR), .arvalid(S_AXI_ARVALID), .arready(S_AXI_ARREADY),
		.rvalid(S_AXI_RVALID), .rready(S_AXI_RREADY));
	initial forever #50 CLOCK = ~CLOCK;
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge CLOCK) begin
		cyc++;
		if (S_AXI_RVALID && S_AXI_RREADY) begin
			e = exp_q.pop_front();
			`CHK({S_AXI_RRESP, S_AXI_RDATA & e[63:32]}, {e[65:64], e[31:0] & e[63:32]})
		end
		if (S_AXI_BVALID && S_AXI_BREADY) begin
			br = bq.pop_front();
			`CHK(S_AXI_BRESP, br)
		end
		if (cyc == 20000) begin
			bad_count++;
			summarize;
		end
	end
	// Masked bits are those the bench cannot predict
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = 2'h0, input logic [31:0] m = 32'hffffffff);
		exp_q.push_back({r, m, d});
		u_psec_mgmt.rd(a);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		bq.push_back(r);
		u_psec_mgmt.wr(a, d);
	endtask
	task automatic pulse(input int n);
		FALSE_CARRIER <= 1'b1;
		repeat (n) @(posedge CLOCK);
		FALSE_CARRIER <= 1'b0;
		@(posedge CLOCK);
	endtask
	task automatic carrier(input logic col, input int k);
		{CARRIER, SYMBOL_ERR, COLLISION} <= {2'h3, col};
		repeat (k) @(posedge CLOCK);
		{CARRIER, SYMBOL_ERR, COLLISION} <= 3'h0;
		@(posedge CLOCK);
	endtask
	initial begin
		void'($urandom(85888));
		repeat (2) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		rd(8'h50, 0);
		rd(8'h54, 0);
		for (i = 0; i < 8; i++) begin
			sts <= 6'($urandom);
			@(posedge CLOCK);
			rd(8'h40, {26'h0, sts}, 0, sts[0] ? 32'hffffffff : 32'hfffffff9);
		end
		pulse(3);
		rd(8'h40, 32'h800, 0, 32'h800);
		rd(8'h50, 3);
		rd(8'h40, 0, 0, 32'h800);
		wr(8'h50, 32'hffffffff);
		pulse(2);
		fork
			rd(8'h50, 2);
			begin @(posedge CLOCK); pulse(1); end
		join
		rd(8'h50, 1);
		pulse(260);
		rd(8'h50, 8'hff);
		carrier(0, 3);
		carrier(1, 2);
		{CARRIER, COLLISION} <= 2'h3;
		@(posedge CLOCK);
		carrier(0, 1);
		carrier(0, 1);
		rd(8'h40, 32'h2000, 0, 32'h2000);
		rd(8'h54, 2);
		rd(8'h40, 0, 0, 32'h2000);
		repeat (256) carrier(0, 1);
		rd(8'h54, 8'hff);
		rd(8'h7c, 0, 2'h2);
		wr(8'h7c, 0, 2'h2);
		`CHK(IRQ, 1'b0)
		wr(8'h64, 1);
		`CHK(IRQ, 1'b1)
		wr(8'h60, 1);
		`CHK(IRQ, 1'b0)
		rd(8'h60, 2);
		rd(8'h64, 1);
		pulse(1);
		`CHK(IRQ, 1'b1)
		summarize;
	end
endmodule // test_psec_status_counters
